// ===== inc/nvm_erase_pkg.sv
package nvm_erase_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W  = 32;

  // clock and operation times
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned T_WRITE_US      = 41;
  localparam int unsigned T_PAGE_MS       = 85;
  localparam int unsigned T_ALL_MS        = 169;
  localparam int unsigned T_UCFG_MS       = T_PAGE_MS;
  localparam int unsigned ACC_PERMILLE    = 1050;
  localparam int unsigned PERMILLE        = 1000;
  localparam int unsigned US_PER_MS       = 1000;
  localparam int unsigned MS_CYCLES       = US_PER_MS * CLK_MHZ;
  localparam int unsigned WRITE_CYCLES    = T_WRITE_US * CLK_MHZ;
  // margin so that start and end latency stay inside the worst case
  localparam int unsigned WRITE_MARGIN    = 4;
  localparam int unsigned MS_MARGIN       = 1;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_READY     = 12'h400;
  localparam logic [ADDR_W-1:0] OFS_CONFIG    = 12'h504;
  localparam logic [ADDR_W-1:0] OFS_PAGE      = 12'h508;
  localparam logic [ADDR_W-1:0] OFS_ALL       = 12'h50C;
  localparam logic [ADDR_W-1:0] OFS_ALIAS     = 12'h510;
  localparam logic [ADDR_W-1:0] OFS_UCFG      = 12'h514;
  localparam logic [ADDR_W-1:0] OFS_PART      = 12'h518;
  localparam logic [ADDR_W-1:0] OFS_PCFG      = 12'h51C;
  localparam logic [ADDR_W-1:0] OFS_PROG_ADDR = 12'h520;
  localparam logic [ADDR_W-1:0] OFS_PROG_DATA = 12'h524;

  // access mode field
  localparam int unsigned       MODE_W     = 2;
  localparam logic [MODE_W-1:0] MODE_READ  = 2'h0;
  localparam logic [MODE_W-1:0] MODE_WRITE = 2'h1;
  localparam logic [MODE_W-1:0] MODE_ERASE = 2'h2;

  localparam int unsigned      DUR_W     = 8;
  localparam logic [DUR_W-1:0] DUR_RESET = 8'h0A;
  localparam int unsigned      READY_BIT = 0;
  localparam int unsigned      GO_BIT    = 0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    OP_NONE    = 3'h0,
    OP_WORD    = 3'h1,
    OP_PAGE    = 3'h2,
    OP_PARTIAL = 3'h3,
    OP_ALL     = 3'h4,
    OP_UCFG    = 3'h5
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } state_t;

endpackage

// ===== rtl/ms_tick_gen.sv
`timescale 1ns/1ps
module ms_tick_gen
  import nvm_erase_pkg::*;
#(
  parameter int unsigned PERIOD = MS_CYCLES
) (
  input  wire logic clk,
  input  wire logic rstN,
  input  wire logic restart,
  output logic      tick
);
  localparam int unsigned    CW   = $clog2(PERIOD + 1);
  localparam logic [CW-1:0]  LAST = CW'(PERIOD - 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_tick;

  // restart aligns the first tick to the start of an operation
  always_comb begin
    next_tick  = (count == LAST) && !restart;
    next_count = (restart || count == LAST) ? '0 : count + CW'(1);
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      count <= next_count;
      tick  <= next_tick;
    end
  end
endmodule

// ===== rtl/op_timer.sv
`timescale 1ns/1ps
module op_timer
  import nvm_erase_pkg::*;
#(
  parameter int unsigned W = CNT_W
) (
  input  wire logic         clk,
  input  wire logic         rstN,
  input  wire logic         load,
  input  wire logic [W-1:0] loadVal,
  input  wire logic         tickEn,
  output logic              done
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic         next_done;

  always_comb begin
    next_count = count;
    next_done  = 1'b0;
    if (load) begin
      next_count = loadVal;
    end else if (tickEn && count != '0) begin
      next_count = count - W'(1);
      next_done  = (count == W'(1));
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      count <= '0;
      done  <= 1'b0;
    end else begin
      count <= next_count;
      done  <= next_done;
    end
  end
endmodule

// ===== rtl/nvm_erase_control.sv
// What this block does
// - a write to the legacy page erase alias starts a full page erase at the written address.
// - writing 1 to the user config erase register erases the user config area, 0 does nothing.
// - the user config erase only starts while the access mode is erase enabled.
// - a write to the partial erase register starts a partial erase at the written page address.
// - the partial erase duration field is in milliseconds and resets to ten.
// - a word program finishes and clears busy within 41 microseconds.
// - a full page erase finishes within 85 milliseconds.
// - an erase of all flash finishes within 169 milliseconds.
// - a partial erase lasts the configured duration (1 ms when set to 0) times a factor of at most 1.05.
// - access mode 0 is read only, 1 write enabled, 2 erase enabled; erases need 2.
// - the ready flag reads 0 while an operation runs and 1 when idle.
`timescale 1ns/1ps
module nvm_erase_control
  import nvm_erase_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES_P = WRITE_CYCLES,
  parameter int unsigned MS_CYCLES_P    = MS_CYCLES
) (
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output op_t                    flashOp,
  output logic [DATA_W-1:0]      flashAddr,
  output logic [DATA_W-1:0]      flashData,
  output logic                   flashStart
);
  logic              rstMeta;
  logic              rstN;
  logic              awHeld;
  logic              wHeld;
  logic [ADDR_W-1:0] wrAddr;
  logic [DATA_W-1:0] wrData;
  logic [3:0]        wrStrb;
  logic [MODE_W-1:0] mode;
  logic [DUR_W-1:0]  duration;
  logic [DATA_W-1:0] pageVal;
  logic [DATA_W-1:0] allVal;
  logic [DATA_W-1:0] aliasVal;
  logic [DATA_W-1:0] ucfgVal;
  logic [DATA_W-1:0] partVal;
  logic [DATA_W-1:0] progAddr;
  logic [DATA_W-1:0] progData;
  state_t            state;
  logic              timerLoad;
  logic [CNT_W-1:0]  timerLoadVal;
  logic              useMsTick;
  logic              msTick;
  logic              timerDone;

  logic              next_awready;
  logic              next_wready;
  logic [1:0]        next_bresp;
  logic              next_bvalid;
  logic              next_arready;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0]        next_rresp;
  logic              next_rvalid;
  logic              next_awHeld;
  logic              next_wHeld;
  logic [ADDR_W-1:0] next_wrAddr;
  logic [DATA_W-1:0] next_wrData;
  logic [3:0]        next_wrStrb;
  logic [MODE_W-1:0] next_mode;
  logic [DUR_W-1:0]  next_duration;
  logic [DATA_W-1:0] next_pageVal;
  logic [DATA_W-1:0] next_allVal;
  logic [DATA_W-1:0] next_aliasVal;
  logic [DATA_W-1:0] next_ucfgVal;
  logic [DATA_W-1:0] next_partVal;
  logic [DATA_W-1:0] next_progAddr;
  logic [DATA_W-1:0] next_progData;
  state_t            next_state;
  op_t               next_flashOp;
  logic [DATA_W-1:0] next_flashAddr;
  logic [DATA_W-1:0] next_flashData;
  logic              next_flashStart;
  logic              next_timerLoad;
  logic [CNT_W-1:0]  next_timerLoadVal;
  logic              next_useMsTick;

  logic              wrCommit;
  logic [ADDR_W-1:0] wrWord;
  logic [ADDR_W-1:0] rdWord;
  logic [DATA_W-1:0] wrVal;
  logic              idle;
  logic              eraseOk;
  op_t               reqOp;
  logic [DATA_W-1:0] reqAddr;
  logic [CNT_W-1:0]  reqLoad;
  logic              reqMs;
  logic [DUR_W-1:0]  durLoad;

  localparam logic [CNT_W-1:0] WORD_LOAD = CNT_W'(WRITE_CYCLES_P - WRITE_MARGIN);
  localparam logic [CNT_W-1:0] PAGE_LOAD = CNT_W'(T_PAGE_MS - MS_MARGIN);
  localparam logic [CNT_W-1:0] ALL_LOAD  = CNT_W'(T_ALL_MS - MS_MARGIN);
  localparam logic [CNT_W-1:0] UCFG_LOAD = CNT_W'(T_UCFG_MS - MS_MARGIN);

  // reset: asynchronous assert, release through two flops
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rstMeta <= 1'b0;
      rstN    <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN    <= rstMeta;
    end
  end

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                              input logic [DATA_W-1:0] data,
                                              input logic [3:0]        strb);
    logic [DATA_W-1:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  assign wrCommit = awHeld && wHeld && !bvalid;
  assign wrWord   = {wrAddr[ADDR_W-1:2], 2'b00};
  assign rdWord   = {araddr[ADDR_W-1:2], 2'b00};
  assign idle     = (state == ST_IDLE);
  assign eraseOk  = idle && (mode == MODE_ERASE);
  assign durLoad  = (duration == '0) ? DUR_W'(1) : duration;

  // write decode: register updates and operation requests
  always_comb begin
    wrVal         = '0;
    reqOp         = OP_NONE;
    reqAddr       = '0;
    reqLoad       = '0;
    reqMs         = 1'b1;
    next_bresp    = bresp;
    next_mode     = mode;
    next_duration = duration;
    next_pageVal  = pageVal;
    next_allVal   = allVal;
    next_aliasVal = aliasVal;
    next_ucfgVal  = ucfgVal;
    next_partVal  = partVal;
    next_progAddr = progAddr;
    next_progData = progData;
    if (wrCommit) begin
      next_bresp = RESP_OKAY;
      unique case (wrWord)
        OFS_CONFIG: begin
          wrVal     = merge(DATA_W'(mode), wrData, wrStrb);
          next_mode = wrVal[MODE_W-1:0];
        end
        OFS_PAGE, OFS_ALIAS: begin
          wrVal = merge((wrWord == OFS_PAGE) ? pageVal : aliasVal, wrData, wrStrb);
          if (wrWord == OFS_PAGE) begin
            next_pageVal = wrVal;
          end else begin
            next_aliasVal = wrVal;
          end
          if (eraseOk) begin
            reqOp   = OP_PAGE;
            reqAddr = wrVal;
            reqLoad = PAGE_LOAD;
          end
        end
        OFS_ALL: begin
          wrVal       = merge(allVal, wrData, wrStrb);
          next_allVal = wrVal;
          if (eraseOk && wrVal[GO_BIT]) begin
            reqOp   = OP_ALL;
            reqLoad = ALL_LOAD;
          end
        end
        OFS_UCFG: begin
          wrVal        = merge(ucfgVal, wrData, wrStrb);
          next_ucfgVal = wrVal;
          if (eraseOk && wrVal[GO_BIT]) begin
            reqOp   = OP_UCFG;
            reqLoad = UCFG_LOAD;
          end
        end
        OFS_PART: begin
          wrVal        = merge(partVal, wrData, wrStrb);
          next_partVal = wrVal;
          if (eraseOk) begin
            reqOp   = OP_PARTIAL;
            reqAddr = wrVal;
            reqLoad = CNT_W'(durLoad);
          end
        end
        OFS_PCFG: begin
          wrVal         = merge(DATA_W'(duration), wrData, wrStrb);
          next_duration = wrVal[DUR_W-1:0];
        end
        OFS_PROG_ADDR: begin
          next_progAddr = merge(progAddr, wrData, wrStrb);
        end
        OFS_PROG_DATA: begin
          wrVal         = merge(progData, wrData, wrStrb);
          next_progData = wrVal;
          if (idle && mode == MODE_WRITE) begin
            reqOp   = OP_WORD;
            reqAddr = progAddr;
            reqLoad = WORD_LOAD;
            reqMs   = 1'b0;
          end
        end
        OFS_READY: begin
        end
        default: begin
          next_bresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // bus handshakes and the operation sequencer
  always_comb begin
    next_awHeld       = awHeld;
    next_wHeld        = wHeld;
    next_wrAddr       = wrAddr;
    next_wrData       = wrData;
    next_wrStrb       = wrStrb;
    next_bvalid       = bvalid;
    // arready comes up after reset and after each read answer is taken
    next_arready      = arready || !rvalid;
    next_rvalid       = rvalid;
    next_rdata        = rdata;
    next_rresp        = rresp;
    next_state        = state;
    next_flashOp      = flashOp;
    next_flashAddr    = flashAddr;
    next_flashData    = flashData;
    next_flashStart   = 1'b0;
    next_timerLoad    = 1'b0;
    next_timerLoadVal = timerLoadVal;
    next_useMsTick    = useMsTick;
    if (awvalid && awready) begin
      next_awHeld = 1'b1;
      next_wrAddr = awaddr;
    end
    if (wvalid && wready) begin
      next_wHeld  = 1'b1;
      next_wrData = wdata;
      next_wrStrb = wstrb;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (wrCommit) begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bvalid = 1'b1;
    end
    // requests while busy are dropped; the response is still OKAY
    if (state == ST_BUSY && timerDone) begin
      next_state   = ST_IDLE;
      next_flashOp = OP_NONE;
    end else if (reqOp != OP_NONE) begin
      next_state        = ST_BUSY;
      next_flashOp      = reqOp;
      next_flashAddr    = reqAddr;
      next_flashData    = (reqOp == OP_WORD) ? wrVal : '0;
      next_flashStart   = 1'b1;
      next_timerLoad    = 1'b1;
      next_timerLoadVal = reqLoad;
      next_useMsTick    = reqMs;
    end
    if (arvalid && arready) begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rresp   = RESP_OKAY;
      unique case (rdWord)
        OFS_READY:     next_rdata = DATA_W'(idle);
        OFS_CONFIG:    next_rdata = DATA_W'(mode);
        OFS_PAGE:      next_rdata = pageVal;
        OFS_ALL:       next_rdata = allVal;
        OFS_ALIAS:     next_rdata = aliasVal;
        OFS_UCFG:      next_rdata = ucfgVal;
        OFS_PART:      next_rdata = partVal;
        OFS_PCFG:      next_rdata = DATA_W'(duration);
        OFS_PROG_ADDR: next_rdata = progAddr;
        OFS_PROG_DATA: next_rdata = progData;
        default: begin
          next_rdata = '0;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
    next_awready = !next_awHeld;
    next_wready  = !next_wHeld;
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      awready      <= 1'b0;
      wready       <= 1'b0;
      bresp        <= RESP_OKAY;
      bvalid       <= 1'b0;
      arready      <= 1'b0;
      rdata        <= '0;
      rresp        <= RESP_OKAY;
      rvalid       <= 1'b0;
      awHeld       <= 1'b0;
      wHeld        <= 1'b0;
      wrAddr       <= '0;
      wrData       <= '0;
      wrStrb       <= '0;
      mode         <= MODE_READ;
      duration     <= DUR_RESET;
      pageVal      <= '0;
      allVal       <= '0;
      aliasVal     <= '0;
      ucfgVal      <= '0;
      partVal      <= '0;
      progAddr     <= '0;
      progData     <= '0;
      state        <= ST_IDLE;
      flashOp      <= OP_NONE;
      flashAddr    <= '0;
      flashData    <= '0;
      flashStart   <= 1'b0;
      timerLoad    <= 1'b0;
      timerLoadVal <= '0;
      useMsTick    <= 1'b1;
    end else begin
      awready      <= next_awready;
      wready       <= next_wready;
      bresp        <= next_bresp;
      bvalid       <= next_bvalid;
      arready      <= next_arready;
      rdata        <= next_rdata;
      rresp        <= next_rresp;
      rvalid       <= next_rvalid;
      awHeld       <= next_awHeld;
      wHeld        <= next_wHeld;
      wrAddr       <= next_wrAddr;
      wrData       <= next_wrData;
      wrStrb       <= next_wrStrb;
      mode         <= next_mode;
      duration     <= next_duration;
      pageVal      <= next_pageVal;
      allVal       <= next_allVal;
      aliasVal     <= next_aliasVal;
      ucfgVal      <= next_ucfgVal;
      partVal      <= next_partVal;
      progAddr     <= next_progAddr;
      progData     <= next_progData;
      state        <= next_state;
      flashOp      <= next_flashOp;
      flashAddr    <= next_flashAddr;
      flashData    <= next_flashData;
      flashStart   <= next_flashStart;
      timerLoad    <= next_timerLoad;
      timerLoadVal <= next_timerLoadVal;
      useMsTick    <= next_useMsTick;
    end
  end

  ms_tick_gen #(.PERIOD(MS_CYCLES_P)) u_ms_tick (
    .clk     (clk_sys),
    .rstN    (rstN),
    .restart (timerLoad),
    .tick    (msTick)
  );

  op_timer #(.W(CNT_W)) u_op_timer (
    .clk     (clk_sys),
    .rstN    (rstN),
    .load    (timerLoad),
    .loadVal (timerLoadVal),
    .tickEn  (useMsTick ? msTick : 1'b1),
    .done    (timerDone)
  );

  // checks: elapsed busy cycles per operation
  logic [63:0] opCycles;
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      opCycles <= '0;
    end else begin
      opCycles <= (state == ST_BUSY) ? opCycles + 64'(1) : '0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstN);

  sequence aliasWrite;
    wrCommit && wrWord == OFS_ALIAS && eraseOk && wrStrb == 4'hF;
  endsequence
  sequence partWrite;
    wrCommit && wrWord == OFS_PART && eraseOk && wrStrb == 4'hF;
  endsequence

  alias_page_start_a: assert property (aliasWrite |=> flashOp == OP_PAGE && flashStart
    && flashAddr == $past(wrData) && state == ST_BUSY)
    else $error("alias write did not start a page erase");
  ucfg_zero_noop_a: assert property (wrCommit && wrWord == OFS_UCFG && idle
    && !wrVal[GO_BIT] |=> state == ST_IDLE && !flashStart)
    else $error("user config erase started on zero");
  ucfg_needs_mode_a: assert property (wrCommit && wrWord == OFS_UCFG && idle
    && mode != MODE_ERASE |=> state == ST_IDLE)
    else $error("user config erase started without erase mode");
  partial_start_a: assert property (partWrite |=> flashOp == OP_PARTIAL
    && flashAddr == $past(wrData) ##1 useMsTick && timerLoadVal == CNT_W'($past(durLoad, 2)))
    else $error("partial erase not started as written");
  dur_reset_a: assert property ($rose(rstN) |-> duration == DUR_RESET)
    else $error("duration reset value wrong");
  word_bound_a: assert property (flashOp == OP_WORD |-> opCycles <= 64'(WRITE_CYCLES_P))
    else $error("word program too long");
  page_bound_a: assert property (flashOp == OP_PAGE
    |-> opCycles <= 64'(T_PAGE_MS) * 64'(MS_CYCLES_P))
    else $error("page erase too long");
  all_bound_a: assert property (flashOp == OP_ALL
    |-> opCycles <= 64'(T_ALL_MS) * 64'(MS_CYCLES_P))
    else $error("erase all too long");
  partial_time_a: assert property (flashOp == OP_PARTIAL ##1 flashOp == OP_NONE
    |-> $past(opCycles) * 64'(PERMILLE)
        <= 64'(durLoad) * 64'(MS_CYCLES_P) * 64'(ACC_PERMILLE))
    else $error("partial erase exceeds accuracy");
  erase_mode_a: assert property ($rose(state == ST_BUSY) && flashOp != OP_WORD
    |-> $past(mode) == MODE_ERASE)
    else $error("erase started outside erase mode");
  ready_read_a: assert property (arvalid && arready && rdWord == OFS_READY
    |=> rvalid && rdata[READY_BIT] == $past(idle))
    else $error("ready flag disagrees with state");
  busy_held_a: assert property (state == ST_BUSY && !timerDone |=> state == ST_BUSY)
    else $error("busy dropped before the timer finished");
endmodule

// ===== rtl/dummy_placeholder_removed.sv
`timescale 1ns/1ps

// ===== verif/nvm_erase_control_bench.sv
`timescale 1ns/1ps
module nvm_erase_control_bench;
  import nvm_erase_pkg::*;
  // shortened counts: WC stands for the word time, MC for one millisecond
  localparam int unsigned WC = 20;
  localparam int unsigned MC = 16;
  logic              clk_sys = 1'b0;
  logic              nrst    = 1'b0;
  logic [ADDR_W-1:0] awaddr  = '0;
  logic [ADDR_W-1:0] araddr  = '0;
  logic [DATA_W-1:0] wdata   = '0;
  logic [3:0]        wstrb   = 4'h0;
  logic              awvalid = 1'b0;
  logic              wvalid  = 1'b0;
  logic              bready  = 1'b0;
  logic              arvalid = 1'b0;
  logic              rready  = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid, flashStart;
  logic [1:0]        bresp, rresp, resp;
  logic [DATA_W-1:0] rdata, flashAddr, flashData, rd;
  op_t               flashOp;
  int                n_fail = 0;
  int                n_compared = 0;
  int                nStart = 0;
  int                n;
  logic [MODE_W-1:0] badModes [3] = '{MODE_READ, MODE_WRITE, 2'h3};

  nvm_erase_control #(.WRITE_CYCLES_P(WC), .MS_CYCLES_P(MC)) i_dut (
    .clk_sys, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .flashOp, .flashAddr, .flashData, .flashStart);

  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (flashStart === 1'b1) nStart <= nStart + 1;

  task automatic chk(input string what, input logic [DATA_W-1:0] seen,
                     input logic [DATA_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // address and data go out together; bready is up from the start
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && k < 50);
    resp = bresp;
    bready <= 1'b0;
    chk("writeAnswered", k < 50, 1);
  endtask

  task automatic rdr(input logic [ADDR_W-1:0] a);
    int k;
    k = 0;
    @(posedge clk_sys);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && k < 50);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    chk("readAnswered", k < 50, 1);
  endtask

  // start one operation, try to restart it while busy, then time it
  task automatic op(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input op_t e,
                    input int lo, input int hi);
    int s;
    wr(OFS_CONFIG, (e == OP_WORD) ? 32'h1 : 32'h2);
    s = nStart;
    wr(a, d);
    repeat (2) @(posedge clk_sys);
    chk("starts", nStart - s, 1);
    chk("flashOp", flashOp, e);
    if (e == OP_PAGE || e == OP_PARTIAL) chk("flashAddr", flashAddr, d);
    if (e == OP_WORD) chk("flashData", flashData, d);
    rdr(OFS_READY);
    chk("readyBusy", rd[READY_BIT], 1'b0);
    s = nStart;
    wr(a, d ^ 32'h1000);
    chk("busyWriteOkay", resp, RESP_OKAY);
    n = 0;
    while (flashOp !== OP_NONE && n <= hi) begin
      @(posedge clk_sys);
      n++;
    end
    chk("busyLong", n <= hi, 1);
    chk("busyShort", n >= lo, 1);
    chk("busyRestart", nStart - s, 0);
    rdr(OFS_READY);
    chk("readyIdle", rd[READY_BIT], 1'b1);
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    n = 0;
    while (awready !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    rdr(OFS_PCFG);
    chk("durationReset", rd, 32'h0000000A);
    rdr(OFS_READY);
    chk("readyReset", rd[READY_BIT], 1'b1);
    rdr(OFS_ALIAS);
    chk("aliasReset", rd, 32'h00000000);
    rdr(12'hFFC);
    chk("unmappedRead", resp, RESP_SLVERR);
    wr(12'hFFC, 32'h5);
    chk("unmappedWrite", resp, RESP_SLVERR);
    $display("test reset done");
    // erases must stay refused in every mode but erase enabled
    foreach (badModes[i]) begin
      wr(OFS_CONFIG, DATA_W'(badModes[i]));
      n = nStart;
      wr(OFS_ALIAS, 32'h1000);
      wr(OFS_UCFG, 32'h1);
      wr(OFS_PART, 32'h2000);
      repeat (2) @(posedge clk_sys);
      chk("modeRefused", nStart - n, 0);
    end
    wr(OFS_CONFIG, 32'h2);
    n = nStart;
    wr(OFS_UCFG, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk("ucfgZero", nStart - n, 0);
    $display("test modes done");
    op(OFS_UCFG, 32'h1, OP_UCFG, 1, T_UCFG_MS * MC);
    op(OFS_ALIAS, 32'h1000, OP_PAGE, 1, T_PAGE_MS * MC);
    op(OFS_ALL, 32'h1, OP_ALL, 1, T_ALL_MS * MC);
    wr(OFS_PROG_ADDR, 32'h40);
    op(OFS_PROG_DATA, 32'hA5A5, OP_WORD, 1, WC);
    // two partial erases of 43 ms together cover the 85 ms page erase time
    wr(OFS_PCFG, 32'h2B);
    rdr(OFS_PCFG);
    chk("durationCfg", rd, 32'h2B);
    op(OFS_PART, 32'h2000, OP_PARTIAL, 43 * MC - 16, 43 * MC * 21 / 20);
    op(OFS_PART, 32'h3000, OP_PARTIAL, 43 * MC - 16, 43 * MC * 21 / 20);
    $display("test erase done");
    test_done();
  end

  initial begin
    #80000;
    n_fail++;
    $display("Error watchdog expected finish seen timeout");
    test_done();
  end
endmodule
